// >>> verilog/port_phy_control_regs.v
// Per-port PHY control bank: advertisement and misc control registers
// for the two PHY ports, plus the MAC return-path bit of ports 3 and 4.
// Assumes a simple synchronous register port driven by the management
// logic; all inputs are synchronous to clk_i.
// Reads answer one cycle after the strobe; writes have no answer.
// Ports 3 and 4 have no PHY, so only their MAC return bit is kept.
`timescale 1ns/1ps
`default_nettype none
`include "port_phy_control_map.vh"

// Contract
// - Advertised flow-control bit offers pause ability when 1; defaults to 1.
// - 100BT full-duplex ability advertised while its bit is set; default set.
// - 100BT half-duplex ability advertised while its bit is set; default set.
// - 10BT full-duplex ability advertised while its bit is set; default set.
// - 10BT half-duplex ability advertised while its bit is set; default set.
// - Blanking bit forces both port indicators high (off); default cleared.
// - Transmit-disable bit turns the port transmitter off; resets to 0.
// - Writing 1 restarts negotiation; bit self-clears; writing 0 does nothing.
// - Power-down bit places the port in power-down; resets to 0.
// - Crossover-disable bit stops automatic MDI/MDI-X selection; resets to 0.
// - With crossover disabled, bit 1 picks MDI (1) or MDI-X (0).
// - Port 1 return bit loops traffic at port 1 MAC, port 2 monitors.
// - Bit 0 at 77 or 93 loops port 3 or 4, port 2 monitors.
// - With negotiation disabled, speed and duplex come from bits 6 and 5.
module port_phy_control_regs (
   // Clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   output reg reg_rvalid_o,
   // Negotiation results from each PHY (index 0 = port 1)
   input wire [1:0] an_done_i,
   input wire [1:0] an_speed_100_i,
   input wire [1:0] an_full_duplex_i,
   // Raw indicator drive from the LED logic
   input wire [1:0] port_indicator_first_i,
   input wire [1:0] port_indicator_second_i,
   // Negotiation controls to each PHY
   output reg [1:0] an_enable_o,
   output reg [1:0] adv_flow_o,
   output reg [1:0] adv_100fd_o,
   output reg [1:0] adv_100hd_o,
   output reg [1:0] adv_10fd_o,
   output reg [1:0] adv_10hd_o,
   output reg [1:0] renegotiate_request_o,
   output reg [1:0] link_speed_100_o,
   output reg [1:0] link_full_duplex_o,
   // PHY analog and pairing controls
   output reg [1:0] tx_disable_o,
   output reg [1:0] power_down_o,
   output reg [1:0] crossover_auto_o,
   output reg [1:0] force_straight_pairing_o,
   // Indicator pins, active low (high = off)
   output reg [1:0] port_indicator_first_o,
   output reg [1:0] port_indicator_second_o,
   // MAC return path per switch port (index 0 = port 1), monitor is port 2
   output reg [3:0] mac_return_path_o
);

   // Register storage
   reg [7:0] advertise [0:1];
   reg [7:0] misc_ctrl [0:3];
   reg [7:0] next_rdata;
   // Loop indices, one per process so no variable has two drivers
   integer i;
   integer n_neg;
   integer n_req;
   integer n_link;
   integer n_pwr;
   integer n_mdi;
   integer n_led;
   integer n_ret;

   // Offset decode: 0..1 advertisement ports, 2..5 misc ports, 7 unmapped
   function [2:0] decode_addr;
      input [7:0] addr;
      begin
         case (addr)
            `ADVERTISE_P1_ADDR: decode_addr = 3'h0;
            `ADVERTISE_P2_ADDR: decode_addr = 3'h1;
            `MISC_CTRL_P1_ADDR: decode_addr = 3'h2;
            `MISC_CTRL_P2_ADDR: decode_addr = 3'h3;
            `MISC_CTRL_P3_ADDR: decode_addr = 3'h4;
            `MISC_CTRL_P4_ADDR: decode_addr = 3'h5;
            default: decode_addr = 3'h7;
         endcase
      end
   endfunction

   // Writable bits of a misc register; ports 3 and 4 have no PHY behind them
   function [7:0] misc_mask;
      input [1:0] port;
      begin
         misc_mask = (port < 2'd2) ? `MISC_WRITE_MASK : `MISC_RETURN_ONLY_MASK;
      end
   endfunction

   // Forced value wins over the negotiated one when told to ignore
   // negotiation; shared by the speed and duplex selections
   function pick_link;
      input use_forced;
      input forced_val;
      input negotiated_val;
      begin
         pick_link = use_forced ? forced_val : negotiated_val;
      end
   endfunction

   // Strobe decode; writes to unmapped offsets fall through unnoticed
   wire [2:0] sel = decode_addr(reg_addr_i);
   wire [1:0] misc_port = sel[1:0] - 2'd2;
   wire adv_hit = reg_wr_i && (sel < 3'h2);
   wire misc_hit = reg_wr_i && (sel >= 3'h2) && (sel <= 3'h5);

   // Advertisement writes; every bit of these registers is writable
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         advertise[0] <= `ADVERTISE_RESET;
         advertise[1] <= `ADVERTISE_RESET;
      end else begin
         if (adv_hit) begin
            advertise[sel[0]] <= reg_wdata_i;
         end
      end
   end

   // Misc writes; restart bit self-clears the cycle after it is set,
   // and a write landing in that same cycle wins over the clear
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            misc_ctrl[i] <= `MISC_CTRL_RESET;
         end
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            misc_ctrl[i][`MISC_RENEG_BIT] <= 1'b0;
         end
         if (misc_hit) begin
            misc_ctrl[misc_port] <= reg_wdata_i & misc_mask(misc_port);
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   always @* begin
      case (sel)
         3'h0: next_rdata = advertise[0];
         3'h1: next_rdata = advertise[1];
         3'h2: next_rdata = misc_ctrl[0];
         3'h3: next_rdata = misc_ctrl[1];
         3'h4: next_rdata = misc_ctrl[2];
         3'h5: next_rdata = misc_ctrl[3];
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data registered one cycle after the read strobe
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   // Ability offers to each PHY, registered so a PHY never sees a
   // half-written advertisement
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         an_enable_o <= 2'h3;
         adv_flow_o <= 2'h3;
         adv_100fd_o <= 2'h3;
         adv_100hd_o <= 2'h3;
         adv_10fd_o <= 2'h3;
         adv_10hd_o <= 2'h3;
      end else begin
         for (n_neg = 0; n_neg < 2; n_neg = n_neg + 1) begin
            an_enable_o[n_neg] <= ~advertise[n_neg][`ADV_AN_DISABLE_BIT];
            adv_flow_o[n_neg] <= advertise[n_neg][`ADV_FLOW_BIT];
            adv_100fd_o[n_neg] <= advertise[n_neg][`ADV_100FD_BIT];
            adv_100hd_o[n_neg] <= advertise[n_neg][`ADV_100HD_BIT];
            adv_10fd_o[n_neg] <= advertise[n_neg][`ADV_10FD_BIT];
            adv_10hd_o[n_neg] <= advertise[n_neg][`ADV_10HD_BIT];
         end
      end
   end

   // Restart pulse; follows the self-clearing bit, one cycle per write
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         renegotiate_request_o <= 2'h0;
      end else begin
         for (n_req = 0; n_req < 2; n_req = n_req + 1) begin
            renegotiate_request_o[n_req] <= misc_ctrl[n_req][`MISC_RENEG_BIT];
         end
      end
   end

   // Speed and duplex handed to the MAC; duplex also falls back to the
   // forced bit while negotiation has not completed
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_speed_100_o <= 2'h3;
         link_full_duplex_o <= 2'h0;
      end else begin
         for (n_link = 0; n_link < 2; n_link = n_link + 1) begin
            link_speed_100_o[n_link] <=
               pick_link(advertise[n_link][`ADV_AN_DISABLE_BIT],
                         advertise[n_link][`ADV_FORCE_SPEED_BIT], an_speed_100_i[n_link]);
            // Forced duplex, also on failed negotiation
            link_full_duplex_o[n_link] <=
               pick_link(advertise[n_link][`ADV_AN_DISABLE_BIT] | ~an_done_i[n_link],
                         advertise[n_link][`ADV_FORCE_DUPLEX_BIT], an_full_duplex_i[n_link]);
         end
      end
   end

   // Transmitter and power controls of each PHY
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_disable_o <= 2'h0;
         power_down_o <= 2'h0;
      end else begin
         for (n_pwr = 0; n_pwr < 2; n_pwr = n_pwr + 1) begin
            tx_disable_o[n_pwr] <= misc_ctrl[n_pwr][`MISC_TX_OFF_BIT];
            power_down_o[n_pwr] <= misc_ctrl[n_pwr][`MISC_PWR_DOWN_BIT];
         end
      end
   end

   // Pair selection; the forced choice is gated here so a stale forced
   // bit cannot fight the automatic crossover logic in the PHY
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         crossover_auto_o <= 2'h3;
         force_straight_pairing_o <= 2'h0;
      end else begin
         for (n_mdi = 0; n_mdi < 2; n_mdi = n_mdi + 1) begin
            crossover_auto_o[n_mdi] <= ~misc_ctrl[n_mdi][`MISC_XOVER_DIS_BIT];
            force_straight_pairing_o[n_mdi] <= misc_ctrl[n_mdi][`MISC_XOVER_DIS_BIT] &
                                               misc_ctrl[n_mdi][`MISC_STRAIGHT_BIT];
         end
      end
   end

   // Indicator pins are active low, so blanking ORs a one onto the raw
   // drive; costs one cycle of lag on the indicators
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         port_indicator_first_o <= 2'h3;
         port_indicator_second_o <= 2'h3;
      end else begin
         for (n_led = 0; n_led < 2; n_led = n_led + 1) begin
            port_indicator_first_o[n_led] <= port_indicator_first_i[n_led] |
                                             misc_ctrl[n_led][`MISC_BLANK_BIT];
            port_indicator_second_o[n_led] <= port_indicator_second_i[n_led] |
                                              misc_ctrl[n_led][`MISC_BLANK_BIT];
         end
      end
   end

   // MAC return path of all four switch ports, port 2 monitors
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mac_return_path_o <= 4'h0;
      end else begin
         for (n_ret = 0; n_ret < 4; n_ret = n_ret + 1) begin
            mac_return_path_o[n_ret] <= misc_ctrl[n_ret][`MISC_RETURN_BIT];
         end
      end
   end

endmodule // port_phy_control_regs

`default_nettype wire

// >>> pkg/port_phy_control_map.vh
// Register map of the per-port PHY control bank.
// Included by the bank module; holds definitions only.
`ifndef PORT_PHY_CONTROL_MAP_VH
`define PORT_PHY_CONTROL_MAP_VH

// Register offsets
`define ADVERTISE_P1_ADDR 8'h2C
`define ADVERTISE_P2_ADDR 8'h3C
`define MISC_CTRL_P1_ADDR 8'h2D
`define MISC_CTRL_P2_ADDR 8'h3D
`define MISC_CTRL_P3_ADDR 8'h4D
`define MISC_CTRL_P4_ADDR 8'h5D

// Advertisement register fields
`define ADV_AN_DISABLE_BIT 7
`define ADV_FORCE_SPEED_BIT 6
`define ADV_FORCE_DUPLEX_BIT 5
`define ADV_FLOW_BIT 4
`define ADV_100FD_BIT 3
`define ADV_100HD_BIT 2
`define ADV_10FD_BIT 1
`define ADV_10HD_BIT 0
`define ADVERTISE_RESET 8'h5F

// Misc control register fields
`define MISC_BLANK_BIT 7
`define MISC_TX_OFF_BIT 6
`define MISC_RENEG_BIT 5
`define MISC_RSVD_BIT 4
`define MISC_PWR_DOWN_BIT 3
`define MISC_XOVER_DIS_BIT 2
`define MISC_STRAIGHT_BIT 1
`define MISC_RETURN_BIT 0
`define MISC_CTRL_RESET 8'h00
`define MISC_WRITE_MASK 8'hEF
`define MISC_RETURN_ONLY_MASK 8'h01

`endif

// >>> verification/port_phy_control_regs_properties.sv
// Port checks of the PHY control bank, bound to it.
// Assumes outputs follow a write two edges after its strobe.
`timescale 1ns/1ps
`default_nettype none
module port_phy_control_regs_checker (
   // Clock, reset, register port
   input wire logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   // Port controls
   input wire logic [1:0] adv_flow_o, adv_100fd_o, adv_100hd_o, adv_10fd_o, adv_10hd_o,
   input wire logic [1:0] renegotiate_request_o, tx_disable_o, an_enable_o, crossover_auto_o,
   input wire logic [1:0] force_straight_pairing_o, link_speed_100_o,
   input wire logic [1:0] port_indicator_first_o, port_indicator_second_o,
   input wire logic [3:0] mac_return_path_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Port 1 write strobes
   wire logic w1 = reg_wr_i && reg_addr_i == 8'h2D;
   wire logic wa = reg_wr_i && reg_addr_i == 8'h2C;
   a_rsvd_reads_zero: assert property (
      reg_rd_i && reg_addr_i == 8'h2D |=> reg_rvalid_o && !reg_rdata_o[4]) else $error("rsvd");
   a_adv_follows: assert property (
      wa |-> ##2 {adv_flow_o[0], adv_100fd_o[0], adv_100hd_o[0], adv_10fd_o[0], adv_10hd_o[0]}
      == $past(reg_wdata_i[4:0], 2)) else $error("advertise");
   a_reneg_pulse: assert property (
      w1 && reg_wdata_i[5] |-> ##2 renegotiate_request_o[0]) else $error("no restart");
   a_reneg_cause: assert property (
      $rose(renegotiate_request_o[0]) |-> $past(w1 && reg_wdata_i[5], 2)) else $error("restart");
   a_tx_off: assert property (
      w1 |-> ##2 tx_disable_o[0] == $past(reg_wdata_i[6], 2)) else $error("tx");
   a_xover_auto: assert property (
      w1 |-> ##2 crossover_auto_o[0] != $past(reg_wdata_i[2], 2)) else $error("xover");
   a_pairing_gate: assert property (
      force_straight_pairing_o[0] |-> !crossover_auto_o[0]) else $error("pairing");
   a_pairing_follows: assert property (
      w1 |-> ##2 force_straight_pairing_o[0] == $past(reg_wdata_i[2] & reg_wdata_i[1], 2))
      else $error("pairing value");
   a_port3_return: assert property (
      reg_wr_i && reg_addr_i == 8'h4D |-> ##2 mac_return_path_o[2] == $past(reg_wdata_i[0], 2))
      else $error("return");
   a_forced_speed: assert property (
      wa && reg_wdata_i[7] |-> ##2 !an_enable_o[0] && link_speed_100_o[0] ==
      $past(reg_wdata_i[6], 2)) else $error("forced");
   a_blank_off: assert property (
      w1 && reg_wdata_i[7] ##1 !w1 |=> port_indicator_first_o[0] && port_indicator_second_o[0])
      else $error("blank");
endmodule // port_phy_control_regs_checker
bind port_phy_control_regs port_phy_control_regs_checker chk (.clk_i, .sys_rst_i, .reg_wr_i,
   .reg_rd_i, .reg_rvalid_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .adv_flow_o, .adv_100fd_o,
   .adv_100hd_o, .adv_10fd_o, .adv_10hd_o, .renegotiate_request_o, .tx_disable_o, .an_enable_o,
   .crossover_auto_o, .force_straight_pairing_o, .link_speed_100_o, .port_indicator_first_o,
   .port_indicator_second_o, .mac_return_path_o);
`default_nettype wire

// >>> verification/link_partner_model.sv
// Remote partner: settles a negotiation a set delay after a restart.
// Assumes it sees the bank's advertisement and restart outputs.
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input wire logic clk_i,
   input wire logic [7:0] dly_i,
   input wire logic [1:0] req_i, fd100_i, hd100_i, fd10_i, hd10_i,
   output var logic [1:0] done_o = 2'h0, spd_o = 2'h0, dup_o = 2'h0
);
   int cnt [2] = '{0, 0};
   // Best shared mode; nothing shared leaves it undone
   always @(posedge clk_i) begin
      for (int p = 0; p < 2; p++) begin
         if (req_i[p]) begin
            done_o[p] <= 1'b0;
            cnt[p] <= dly_i;
         end else if (cnt[p] > 0) begin
            cnt[p] <= cnt[p] - 1;
            if (cnt[p] == 1) begin
               done_o[p] <= fd100_i[p] | hd100_i[p] | fd10_i[p] | hd10_i[p];
               spd_o[p] <= fd100_i[p] | hd100_i[p];
               dup_o[p] <= fd100_i[p] | (!hd100_i[p] & fd10_i[p]);
            end
         end
      end
   end
endmodule // link_partner_model
`default_nettype wire

// >>> verification/port_phy_control_regs_test.sv
// Self-checking bench for the PHY control bank and its partner.
// Assumes one-cycle strobes and a registered read answer.
`timescale 1ns/1ps
`default_nettype none
module port_phy_control_regs_test;
   logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, reg_rvalid_o;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d, dly = 8'h01;
   logic [1:0] li1 = 2'h0, li2 = 2'h0, ae, fl, f1, h1, f0, h0, rq, sp, dp, tx, pd, xa, st;
   logic [1:0] lo1, lo2, dn, asp, adp;
   logic [3:0] ret;
   logic [16:0] lfsr = 17'h13E95;
   logic [7:0] expq[$];
   logic [7:0] offs [7] = '{8'h2C, 8'h3C, 8'h2D, 8'h3D, 8'h4D, 8'h5D, 8'h10};
   string nameq[$];
   int miscompares = 0, tests_run = 0, cycles = 0, n;
   port_phy_control_regs DUT (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
      .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .an_done_i(dn), .an_speed_100_i(asp),
      .an_full_duplex_i(adp), .port_indicator_first_i(li1), .port_indicator_second_i(li2),
      .an_enable_o(ae), .adv_flow_o(fl), .adv_100fd_o(f1), .adv_100hd_o(h1), .adv_10fd_o(f0),
      .adv_10hd_o(h0), .renegotiate_request_o(rq), .link_speed_100_o(sp),
      .link_full_duplex_o(dp), .tx_disable_o(tx), .power_down_o(pd), .crossover_auto_o(xa),
      .force_straight_pairing_o(st), .port_indicator_first_o(lo1),
      .port_indicator_second_o(lo2), .mac_return_path_o(ret));
   link_partner_model peer (.clk_i, .dly_i(dly), .req_i(rq), .fd100_i(f1), .hd100_i(h1),
      .fd10_i(f0), .hd10_i(h0), .done_o(dn), .spd_o(asp), .dup_o(adp));
   function automatic logic [16:0] step(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   initial forever #25 clk_i = ~clk_i;
   // Noisy raw indicators, so blanking is seen against changes
   always @(posedge clk_i) begin
      lfsr <= step(lfsr);
      {li1, li2} <= lfsr[3:0];
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         summarize();
      end
   end
   // Oldest note is due when a read answer appears
   always @(posedge clk_i) begin
      if (reg_rvalid_o === 1'b1) begin
         check8(nameq.pop_front(), expq.pop_front(), reg_rdata_o);
      end
   end
   task automatic check8(input string nm, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e, input string nm);
      expq.push_back(e);
      nameq.push_back(nm);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
   endtask
   task automatic settle(input int c);
      repeat (c) @(negedge clk_i);
   endtask
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      foreach (offs[i]) begin
         d = offs[i];
         rd(d, d[3:0] == 4'hC ? 8'h5F : 8'h00, "reset");
      end
      $display("Test reset done");
      for (int p = 0; p < 2; p++) begin
         d = lfsr[7:0] & 8'h7F;
         wr(8'h2C + 8'(p * 16), d);
         rd(8'h2C + 8'(p * 16), d, "advertise");
         settle(1);
         check8("adv_out", {3'h0, d[4:0]}, {3'h0, fl[p], f1[p], h1[p], f0[p], h0[p]});
      end
      $display("Test advertise done");
      wr(8'h2D, 8'hFF);
      wr(8'h4D, 8'hFF);
      wr(8'h10, 8'hFF);
      rd(8'h2D, 8'hCF, "misc");
      rd(8'h4D, 8'h01, "misc3");
      rd(8'h10, 8'h00, "unmapped");
      settle(1);
      check8("return", 8'h05, {4'h0, ret});
      check8("misc_out", 8'h0D, {4'h0, tx[0], pd[0], xa[0], st[0]});
      check8("blank", 8'h03, {6'h0, lo1[0], lo2[0]});
      wr(8'h2D, 8'h02);
      settle(2);
      check8("misc_off", 8'h02, {4'h0, tx[0], pd[0], xa[0], st[0]});
      $display("Test misc done");
      for (int k = 0; k < 2; k++) begin
         dly <= k ? 8'h28 : 8'h01;
         // Abilities first, then the restart
         wr(8'h2C, k ? 8'h02 : 8'h04);
         wr(8'h2D, 8'h20);
         settle(4);
         for (n = 0; n < 100 && dn[0] !== 1'b1; n++) settle(1);
         // A partner that never settles counts as a mismatch
         if (n == 100) miscompares++;
         settle(2);
         check8("link", k ? 8'h01 : 8'h02, {6'h0, sp[0], dp[0]});
      end
      wr(8'h2C, 8'hE0);
      settle(2);
      check8("forced", 8'h03, {5'h0, ae[0], sp[0], dp[0]});
      $display("Test negotiation done");
      summarize();
   end
endmodule // port_phy_control_regs_test
`default_nettype wire
